// [include/rcs_params.svh]
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ==========================================================
// Register offsets
`define RCS_OFF_TRIM_HIGH   8'h00
`define RCS_OFF_TRIM_LOW    8'h01
`define RCS_OFF_SWITCH_CSR  8'h02
`define RCS_OFF_UTRIM_CTRL  8'h03
`define RCS_OFF_FACT_HIGH   8'h04
`define RCS_OFF_FACT_LOW    8'h05
`define RCS_OFF_USER_HIGH   8'h06
`define RCS_OFF_USER_LOW    8'h07

// ==========================================================
// Field positions
`define RCS_TRIM_LOW_MSB    6
`define RCS_TRIM_LOW_LSB    5
`define RCS_CSR_OSC_SEL     0
`define RCS_CSR_INTERNAL_RC_ACTIVE_FLAG     1
`define RCS_CSR_WU_FLAG     2
`define RCS_UTC_PGM         0
`define RCS_UTC_LAT         1

// ==========================================================
// Reset values
`define RCS_TRIM_HIGH_RST   8'hff
`define RCS_TRIM_LOW_RST    8'h60
`define RCS_NV_ERASED       8'hff

// ==========================================================
// Option field codes
`define RCS_STARTUP_CLOCK_OPTION_EXT       2'h0
`define RCS_STARTUP_CLOCK_OPTION_RC        2'h1
`define RCS_STARTUP_CLOCK_OPTION_WU        2'h3

// ==========================================================
// Timing
`define RCS_CLK_MHZ         125
`define RCS_PROG_TIME_US    5
`define RCS_PROG_CYCLES     (`RCS_PROG_TIME_US * `RCS_CLK_MHZ)
`define RCS_WU_WAIT_EDGES   3
`define RCS_RC_WAIT_EDGES   8
`define RCS_INTERNAL_RC_ACTIVE_FLAG_EDGES   2

`endif

// [include/rcs_pkg.sv]
package rcs_pkg;
    typedef enum logic [2:0] {
        RCS_ON_RC    = 3'b000,
        RCS_TO_WU    = 3'b001,
        RCS_WU_EDGE  = 3'b010,
        RCS_ON_WU    = 3'b011,
        RCS_RC_COUNT = 3'b100,
        RCS_WU_CLR   = 3'b101,
        RCS_RC_SET   = 3'b110,
        RCS_RC_EDGE  = 3'b111
    } rcs_sw_state_t;
    typedef logic [7:0] rcs_byte_t;
endpackage

// [hw/rcs_clock_cal.sv]
`timescale 1ns/1ps
`include "rcs_params.svh"
// Summary of operation
// - Oscillator trim is 10 bits: high register plus low register bits 6:5.
// - Every reset returns the trim high register to ffh.
// - Factory trim bytes are read-only; writes to them are ignored.
// - Programming session entry forces the internal RC as clock source.
// - With latch enable set, program clear and no read-out protection, user-area writes are latched.
// - Setting program start copies latched data into the user cells when the programming time has run out.
// - At end of programming, program start and latch enable clear together.
// - User-area reads with latch enable set leave the data bus undriven.
// - User-area writes with latch enable clear are ignored.
// - Read-out protection blocks user bytes; removal erases them.
// - Startup option can select the wake-up oscillator as startup clock.
// - Selecting wake-up clears RC active flag and holds clock high.
// - After 3 wake-up cycles set its flag, switch on its edge, stop RC.
// - Deselecting wake-up starts RC and counts 8 RC cycles in 4 bits.
// - Then clear wake-up flag, set Internal_rc_active_flag after 2 cycles, switch, stop.
// - Unless the external clock is selected, internal RC runs while it is the selected source and until the output has moved to wake-up.
// - Wake-up oscillator turns on in auto-wake-up halt with RC selected.
// - Wake-up oscillator always runs when external clock is selected, except while the in-circuit link forces the RC.
module rcs_clock_cal
    import rcs_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic [7:0]       addr,
    input  wire rcs_pkg::rcs_byte_t wdata,
    input  wire logic             wr_stb,
    input  wire logic             rd_stb,
    output      rcs_pkg::rcs_byte_t rdata,
    output      logic             rdata_oe_b,
    input  wire rcs_pkg::rcs_byte_t factory_trim_high,
    input  wire rcs_pkg::rcs_byte_t factory_trim_low,
    input  wire logic [1:0]       startup_clock_option,
    input  wire logic             in_circuit_link_38,
    input  wire logic             readout_protect,
    input  wire logic             readout_unprotect,
    input  wire logic             halt_auto_wakeup,
    input  wire logic             rc_osc_level,
    input  wire logic             wu_osc_level,
    output      logic [9:0]       trim_value,
    output      logic             rc_osc_en,
    output      logic             wu_osc_en,
    output      logic             clk_out,
    output      logic             prog_busy
);
    import rcs_pkg::*;

    // ======================================================
    // Register state
    rcs_byte_t     rc_trim_high_reg;
    logic [1:0]    rc_trim_low_reg;
    logic          oscillator_select_reg;
    logic          internal_rc_active_flag_reg;
    logic          wakeup_osc_active_flag_reg;
    logic          user_trim_latch_enable_reg;
    logic          user_trim_program_start_reg;
    rcs_byte_t     user_trim_high_byte_reg;
    rcs_byte_t     user_trim_low_byte_reg;
    rcs_byte_t     latch_high_reg;
    rcs_byte_t     latch_low_reg;
    logic [15:0]   prog_cnt_reg;
    rcs_byte_t     rdata_reg;
    logic          rdata_oe_b_reg;
    logic          opt_taken_reg;
    logic [1:0]    startup_clock_option_reg;
    rcs_sw_state_t sw_state_reg;
    rcs_sw_state_t sw_state_next;
    logic [3:0]    edge_cnt_reg;
    logic          rc_prev_reg;
    logic          wu_prev_reg;
    logic          clk_out_reg;
    logic          rc_en_reg;
    logic          wu_en_reg;

    // ======================================================
    // Address decode
    wire sel_hi   = (addr == `RCS_OFF_TRIM_HIGH);
    wire sel_lo   = (addr == `RCS_OFF_TRIM_LOW);
    wire sel_csr  = (addr == `RCS_OFF_SWITCH_CSR);
    wire sel_utc  = (addr == `RCS_OFF_UTRIM_CTRL);
    wire sel_fhi  = (addr == `RCS_OFF_FACT_HIGH);
    wire sel_flo  = (addr == `RCS_OFF_FACT_LOW);
    wire sel_uhi  = (addr == `RCS_OFF_USER_HIGH);
    wire sel_ulo  = (addr == `RCS_OFF_USER_LOW);
    wire sel_user = sel_uhi | sel_ulo;

    // User-area access qualification
    wire prog_end   = user_trim_program_start_reg &&
                      (prog_cnt_reg == 16'(`RCS_PROG_CYCLES - 1));
    wire latch_ok   = user_trim_latch_enable_reg &&
                      !user_trim_program_start_reg && !readout_protect;
    wire wr_latch   = wr_stb && sel_user && latch_ok;
    wire start_pgm  = wr_stb && sel_utc && latch_ok &&
                      wdata[`RCS_UTC_PGM];
    wire wr_utc     = wr_stb && sel_utc && !user_trim_program_start_reg;
    wire user_float = sel_user && user_trim_latch_enable_reg;

    // Clock source qualification
    wire force_rc  = in_circuit_link_38;
    wire want_wu   = oscillator_select_reg && !force_rc;
    wire ext_sel   = (startup_clock_option_reg == `RCS_STARTUP_CLOCK_OPTION_EXT) && !force_rc;
    wire rc_rise   = rc_osc_level && !rc_prev_reg;
    wire wu_rise   = wu_osc_level && !wu_prev_reg;
    wire on_rc_now = (sw_state_reg == RCS_ON_RC);

    // Read data mux
    rcs_byte_t rd_mux;
    assign rd_mux =
        sel_hi  ? rc_trim_high_reg :
        sel_lo  ? {1'b0, rc_trim_low_reg, 5'h00} :
        sel_csr ? {5'h00, wakeup_osc_active_flag_reg,
                   internal_rc_active_flag_reg, oscillator_select_reg} :
        sel_utc ? {6'h00, user_trim_latch_enable_reg,
                   user_trim_program_start_reg} :
        sel_fhi ? factory_trim_high :
        sel_flo ? {1'b0, factory_trim_low[6:5], 5'h00} :
        (sel_uhi && !readout_protect) ? user_trim_high_byte_reg :
        (sel_ulo && !readout_protect) ? user_trim_low_byte_reg :
        8'h00;

    // ======================================================
    // Trim registers, reset to default every reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_trim_high_reg <= `RCS_TRIM_HIGH_RST;
            rc_trim_low_reg  <= 2'(`RCS_TRIM_LOW_RST >> 5);
        end else if (wr_stb && sel_hi) begin
            rc_trim_high_reg <= wdata;
        end else if (wr_stb && sel_lo) begin
            rc_trim_low_reg  <=
                wdata[`RCS_TRIM_LOW_MSB:`RCS_TRIM_LOW_LSB];
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg      <= 8'h00;
            rdata_oe_b_reg <= 1'b1;
        end else begin
            rdata_reg      <= (rd_stb && !user_float) ? rd_mux : 8'h00;
            rdata_oe_b_reg <= !(rd_stb && !user_float);
        end
    end

    // ======================================================
    // User trim latch and program control
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            user_trim_latch_enable_reg  <= 1'b0;
            user_trim_program_start_reg <= 1'b0;
        end else if (prog_end) begin
            user_trim_latch_enable_reg  <= 1'b0;
            user_trim_program_start_reg <= 1'b0;
        end else if (start_pgm) begin
            user_trim_program_start_reg <= 1'b1;
        end else if (wr_utc) begin
            user_trim_latch_enable_reg  <= wdata[`RCS_UTC_LAT];
        end
    end

    // Programming cycle timer
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prog_cnt_reg <= 16'h0000;
        end else if (user_trim_program_start_reg && !prog_end) begin
            prog_cnt_reg <= prog_cnt_reg + 16'h0001;
        end else begin
            prog_cnt_reg <= 16'h0000;
        end
    end

    // Latches for the two user bytes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_high_reg <= `RCS_NV_ERASED;
            latch_low_reg  <= `RCS_NV_ERASED;
        end else if (wr_latch && sel_uhi) begin
            latch_high_reg <= wdata;
        end else if (wr_latch && sel_ulo) begin
            latch_low_reg  <= wdata;
        end
    end

    // Non-volatile user cells, erased on protection removal
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            user_trim_high_byte_reg <= `RCS_NV_ERASED;
            user_trim_low_byte_reg  <= `RCS_NV_ERASED;
        end else if (readout_unprotect) begin
            user_trim_high_byte_reg <= `RCS_NV_ERASED;
            user_trim_low_byte_reg  <= `RCS_NV_ERASED;
        end else if (prog_end) begin
            user_trim_high_byte_reg <= latch_high_reg;
            user_trim_low_byte_reg  <= latch_low_reg;
        end
    end

    // ======================================================
    // Startup option captured once after reset release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            opt_taken_reg <= 1'b0;
            startup_clock_option_reg     <= `RCS_STARTUP_CLOCK_OPTION_RC;
        end else if (!opt_taken_reg) begin
            opt_taken_reg <= 1'b1;
            startup_clock_option_reg     <= startup_clock_option;
        end
    end

    // Oscillator select bit, preset by the startup option
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oscillator_select_reg <= 1'b0;
        end else if (!opt_taken_reg) begin
            oscillator_select_reg <=
                (startup_clock_option == `RCS_STARTUP_CLOCK_OPTION_WU);
        end else if (wr_stb && sel_csr) begin
            oscillator_select_reg <= wdata[`RCS_CSR_OSC_SEL];
        end
    end

    // ======================================================
    // Handover state machine
    always_comb begin
        sw_state_next = sw_state_reg;
        case (sw_state_reg)
            RCS_ON_RC: begin
                if (want_wu) begin
                    sw_state_next = RCS_TO_WU;
                end
            end
            RCS_TO_WU: begin
                if (wu_rise &&
                    edge_cnt_reg == 4'(`RCS_WU_WAIT_EDGES - 1)) begin
                    sw_state_next = RCS_WU_EDGE;
                end
            end
            RCS_WU_EDGE: begin
                if (wu_rise) begin
                    sw_state_next = RCS_ON_WU;
                end
            end
            RCS_ON_WU: begin
                if (!want_wu) begin
                    sw_state_next = RCS_RC_COUNT;
                end
            end
            RCS_RC_COUNT: begin
                if (rc_rise &&
                    edge_cnt_reg == 4'(`RCS_RC_WAIT_EDGES - 1)) begin
                    sw_state_next = RCS_WU_CLR;
                end
            end
            RCS_WU_CLR: begin
                if (wu_rise) begin
                    sw_state_next = RCS_RC_SET;
                end
            end
            RCS_RC_SET: begin
                if (rc_rise &&
                    edge_cnt_reg == 4'(`RCS_INTERNAL_RC_ACTIVE_FLAG_EDGES - 1)) begin
                    sw_state_next = RCS_RC_EDGE;
                end
            end
            RCS_RC_EDGE: begin
                if (rc_rise) begin
                    sw_state_next = RCS_ON_RC;
                end
            end
            default: begin
                sw_state_next = RCS_ON_RC;
            end
        endcase
    end

    // State register and edge history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_state_reg <= RCS_ON_RC;
            rc_prev_reg  <= 1'b0;
            wu_prev_reg  <= 1'b0;
        end else begin
            sw_state_reg <= sw_state_next;
            rc_prev_reg  <= rc_osc_level;
            wu_prev_reg  <= wu_osc_level;
        end
    end

    // Edge counter, cleared on every state change
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_cnt_reg <= 4'h0;
        end else if (sw_state_next != sw_state_reg) begin
            edge_cnt_reg <= 4'h0;
        end else if ((sw_state_reg == RCS_TO_WU && wu_rise) ||
                     (sw_state_reg == RCS_RC_COUNT && rc_rise) ||
                     (sw_state_reg == RCS_RC_SET && rc_rise)) begin
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end

    // Active flags: wake-up flag moved on wake-up edges, RC flag set on an RC edge and cleared on selection
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            internal_rc_active_flag_reg <= 1'b1;
            wakeup_osc_active_flag_reg  <= 1'b0;
        end else begin
            if (sw_state_reg == RCS_ON_RC && want_wu) begin
                internal_rc_active_flag_reg <= 1'b0;
            end else if (sw_state_reg == RCS_RC_SET &&
                         sw_state_next == RCS_RC_EDGE) begin
                internal_rc_active_flag_reg <= 1'b1;
            end
            if (sw_state_reg == RCS_TO_WU &&
                sw_state_next == RCS_WU_EDGE) begin
                wakeup_osc_active_flag_reg <= 1'b1;
            end else if (sw_state_reg == RCS_WU_CLR && wu_rise) begin
                wakeup_osc_active_flag_reg <= 1'b0;
            end
        end
    end

    // Output clock: held high in handover, follows the owner otherwise
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_out_reg <= 1'b1;
        end else if (sw_state_next == RCS_ON_RC) begin
            clk_out_reg <= rc_osc_level;
        end else if (sw_state_next == RCS_ON_WU) begin
            clk_out_reg <= wu_osc_level;
        end else begin
            clk_out_reg <= 1'b1;
        end
    end

    // Oscillator enables
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_en_reg <= 1'b1;
            wu_en_reg <= 1'b0;
        end else begin
            // RC keeps running until the output has moved to wake-up
            rc_en_reg <= force_rc || (!ext_sel &&
                         sw_state_next != RCS_ON_WU);
            wu_en_reg <= ext_sel ||
                         (on_rc_now && halt_auto_wakeup) ||
                         (!ext_sel && sw_state_next != RCS_ON_RC);
        end
    end

    // ======================================================
    // Outputs
    assign rdata      = rdata_reg;
    assign rdata_oe_b = rdata_oe_b_reg;
    assign trim_value = {rc_trim_high_reg, rc_trim_low_reg};
    assign rc_osc_en  = rc_en_reg;
    assign wu_osc_en  = wu_en_reg;
    assign clk_out    = clk_out_reg;
    assign prog_busy  = user_trim_program_start_reg;
endmodule

// [dv/rcs_clock_cal_sva.sv]
`timescale 1ns/1ps
module rcs_cal_chk (
    input wire logic               ref_clk,
    input wire logic               rst_b,
    input wire logic [7:0]         addr,
    input wire rcs_pkg::rcs_byte_t wdata,
    input wire logic               wr_stb,
    input wire logic               rd_stb,
    input wire rcs_pkg::rcs_byte_t rdata,
    input wire logic               rdata_oe_b,
    input wire rcs_pkg::rcs_byte_t factory_trim_high,
    input wire logic [1:0]         startup_clock_option,
    input wire logic               in_circuit_link_38,
    input wire logic               halt_auto_wakeup,
    input wire logic               rc_osc_level,
    input wire logic               wu_osc_level,
    input wire logic [9:0]         trim_value,
    input wire logic               rc_osc_en,
    input wire logic               wu_osc_en,
    input wire logic               clk_out,
    input wire logic               prog_busy
);
    import rcs_pkg::*;
    logic [9:0] busy_cnt_reg;
    logic [9:0] busy_cnt_next;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Length of the running programming cycle
    assign busy_cnt_next = prog_busy ? busy_cnt_reg + 10'h1 : 10'h0;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_cnt_reg <= 10'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    // ==========================================================
    // Request sequences
    sequence trim_hi_wr;
        wr_stb && addr == 8'h00;
    endsequence
    sequence sel_wu_req;
        wr_stb && addr == 8'h02 && wdata[0] && !wu_osc_en
            && !in_circuit_link_38;
    endsequence

    // ==========================================================
    // Trim, factory bytes and programming
    trim_high_a: assert property (trim_hi_wr |=>
        trim_value[9:2] == $past(wdata)) else $error("trim high lost");
    trim_low_a: assert property (wr_stb && addr == 8'h01 |=>
        trim_value[1:0] == $past(wdata[6:5])) else $error("trim low lost");
    trim_reset_a: assert property ($rose(rst_b) |->
        trim_value == 10'h3ff) else $error("trim not ff after reset");
    factory_read_a: assert property (rd_stb && addr == 8'h04 |=>
        !rdata_oe_b && rdata == $past(factory_trim_high))
        else $error("factory byte read wrong");
    prog_length_a: assert property ($fell(prog_busy) |->
        busy_cnt_reg inside {[10'h270:10'h272]})
        else $error("programming cycle length wrong");

    // ==========================================================
    // Clock switch
    hold_high_a: assert property (sel_wu_req |=> ##1 clk_out [*3])
        else $error("clock not held high");
    wu_take_a: assert property ($fell(rc_osc_en) &&
        startup_clock_option != 2'h0 |=> clk_out == $past(wu_osc_level))
        else $error("clock not on wake-up source");
    rc_take_a: assert property ($fell(wu_osc_en) &&
        startup_clock_option != 2'h0 |=> clk_out == $past(rc_osc_level))
        else $error("clock not on internal source");
    rc_off_a: assert property (!rc_osc_en [*3] |-> wu_osc_en)
        else $error("both oscillators stopped");
    ext_wu_a: assert property (startup_clock_option == 2'h0 &&
        $past(rst_b, 3) |-> wu_osc_en) else $error("wake-up off");
    halt_wu_a: assert property ($rose(halt_auto_wakeup) &&
        !wu_osc_en |-> ##[1:2] wu_osc_en) else $error("no halt wake-up");
    link_rc_a: assert property (in_circuit_link_38 && rc_osc_en |=>
        rc_osc_en) else $error("internal source dropped");
endmodule

bind rcs_clock_cal rcs_cal_chk u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .rdata_oe_b(rdata_oe_b), .factory_trim_high(factory_trim_high),
    .startup_clock_option(startup_clock_option),
    .in_circuit_link_38(in_circuit_link_38),
    .halt_auto_wakeup(halt_auto_wakeup), .rc_osc_level(rc_osc_level),
    .wu_osc_level(wu_osc_level), .trim_value(trim_value),
    .rc_osc_en(rc_osc_en), .wu_osc_en(wu_osc_en), .clk_out(clk_out),
    .prog_busy(prog_busy)
);

// [dv/tb.sv]
`timescale 1ns/1ps
module tb;
    import rcs_pkg::*;
    logic       ref_clk;
    logic       rst_b;
    logic [7:0] addr;
    rcs_byte_t  wdata;
    logic       wr_stb;
    logic       rd_stb;
    rcs_byte_t  rdata;
    logic       rdata_oe_b;
    rcs_byte_t  fac_hi;
    rcs_byte_t  fac_lo;
    logic [1:0] opt;
    logic       link38;
    logic       prot;
    logic       unprot;
    logic       halt;
    logic       rc_lvl = 1'b0;
    logic       wu_lvl = 1'b0;
    logic [9:0] trim_value;
    logic       rc_en;
    logic       wu_en;
    logic       clk_out;
    logic       prog_busy;
    logic [4:0] ph = 5'h0;
    logic [9:0] d;
    logic       oe;
    int         err_total;
    int         n_checks;
    int         m_hi;
    int         m_lo;
    int         m_usr[2];

    // ==========================================================
    // Clock and oscillators, which stay low while disabled
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        ph <= ph + 5'h1;
        rc_lvl <= rc_en & ph[1];
        wu_lvl <= wu_en & ph[4];
    end

    rcs_clock_cal DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .rdata_oe_b(rdata_oe_b), .factory_trim_high(fac_hi),
        .factory_trim_low(fac_lo), .startup_clock_option(opt),
        .in_circuit_link_38(link38), .readout_protect(prot),
        .readout_unprotect(unprot), .halt_auto_wakeup(halt),
        .rc_osc_level(rc_lvl), .wu_osc_level(wu_lvl),
        .trim_value(trim_value), .rc_osc_en(rc_en), .wu_osc_en(wu_en),
        .clk_out(clk_out), .prog_busy(prog_busy)
    );

    // ==========================================================
    // Verdict, compares and bus cycles
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_v(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input rcs_byte_t v);
        @(posedge ref_clk);
        addr <= a;
        wdata <= v;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = {2'h0, rdata};
        oe = rdata_oe_b;
    endtask

    // Bounded wait for a register field to reach a value
    task automatic poll(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] v);
        int i;
        for (i = 0; i < 400; i++) begin
            rd(a);
            if ((d[7:0] & m) === v) break;
        end
        chk_b(i < 400, 1'b1);
        if (i == 400) test_done;
    endtask

    task automatic do_reset(input logic [1:0] o);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        opt <= o;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        m_hi = 'hff;
        m_lo = 'h60;
        m_usr = '{'hff, 'hff};
        @(posedge ref_clk);
        #1 chk_v(trim_value, 10'h3ff);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {rst_b, wr_stb, rd_stb, link38, prot, unprot, halt} = 7'h0;
        {addr, wdata, opt} = 18'h0;
        err_total = 0;
        n_checks = 0;
        d = 10'($urandom(32'h5e757298));
        fac_hi = 8'($urandom);
        fac_lo = 8'($urandom);
        do_reset(2'h1);
        rd(8'h01);
        chk_v(d, 10'(m_lo));
        for (int k = 0; k < 8; k++) begin
            m_hi = $urandom & 'hff;
            m_lo = $urandom & 'h60;
            wr(8'h00, m_hi[7:0]);
            wr(8'h01, m_lo[7:0] | 8'($urandom & 'h9f));
            #1 chk_v(trim_value, {m_hi[7:0], m_lo[6:5]});
            rd(8'h00);
            chk_v(d, 10'(m_hi));
        end
        do_reset(2'h1);
        rd(8'h04);
        chk_v(d, 10'(fac_hi));
        wr(8'h04, ~fac_hi);
        rd(8'h04);
        chk_v(d, 10'(fac_hi));
        rd(8'h05);
        chk_v(d, 10'(fac_lo & 8'h60));
        rd(8'h3c);
        chk_b(oe, 1'b0);
        chk_v(d, 10'h0);
        $display("test trim and factory done");
        // User bytes: refused write, latch, program
        wr(8'h06, 8'h12);
        rd(8'h06);
        chk_v(d, 10'(m_usr[0]));
        wr(8'h03, 8'h02);
        rd(8'h06);
        chk_b(oe, 1'b1);
        m_usr[0] = $urandom & 'hff;
        m_usr[1] = $urandom & 'hff;
        wr(8'h06, m_usr[0][7:0]);
        wr(8'h07, m_usr[1][7:0]);
        wr(8'h03, 8'h03);
        #1 chk_b(prog_busy, 1'b1);
        poll(8'h03, 8'h01, 8'h00);
        chk_v(d, 10'h0);
        rd(8'h06);
        chk_v(d, 10'(m_usr[0]));
        rd(8'h07);
        chk_v(d, 10'(m_usr[1]));
        @(posedge ref_clk);
        prot <= 1'b1;
        rd(8'h06);
        chk_v(d, 10'h0);
        @(posedge ref_clk);
        unprot <= 1'b1;
        prot <= 1'b0;
        @(posedge ref_clk);
        unprot <= 1'b0;
        rd(8'h07);
        chk_v(d, 10'(m_usr[1] | 'hff));
        $display("test user trim done");
        // Handover to the wake-up source and back
        wr(8'h02, 8'h01);
        rd(8'h02);
        chk_v(d & 10'h6, 10'h0);
        poll(8'h02, 8'h04, 8'h04);
        chk_v(d & 10'h6, 10'h4);
        repeat (40) @(posedge ref_clk);
        #1 chk_b(rc_en, 1'b0);
        wr(8'h02, 8'h00);
        repeat (2) @(posedge ref_clk);
        #1 chk_b(rc_en, 1'b1);
        poll(8'h02, 8'h02, 8'h02);
        chk_v(d & 10'h6, 10'h2);
        repeat (8) @(posedge ref_clk);
        #1 chk_b(wu_en, 1'b0);
        @(posedge ref_clk);
        halt <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk_b(wu_en, 1'b1);
        @(posedge ref_clk);
        halt <= 1'b0;
        link38 <= 1'b1;
        wr(8'h02, 8'h01);
        repeat (150) @(posedge ref_clk);
        #1 chk_b(rc_en, 1'b1);
        rd(8'h02);
        chk_v(d & 10'h4, 10'h0);
        wr(8'h02, 8'h00);
        @(posedge ref_clk);
        link38 <= 1'b0;
        $display("test clock switch done");
        do_reset(2'h3);
        poll(8'h02, 8'h04, 8'h04);
        do_reset(2'h0);
        repeat (4) @(posedge ref_clk);
        #1 chk_b(wu_en, 1'b1);
        chk_b(rc_en, 1'b0);
        $display("test startup option done");
        test_done;
    end
endmodule
